// ===== hw/lsmc_ctrl.sv
// low supply monitor control with apb registers
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module lsmc_ctrl
    import lsmc_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [15:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_below_fall_rst,
    input  wire logic        i_above_rise_rst,
    input  wire logic        i_below_fall_warn,
    input  wire logic        i_above_rise_warn,
    input  wire logic        i_stop_mode,
    input  wire logic        i_wait_mode,
    output logic             o_monitor_power,
    output logic             o_sys_reset,
    output logic             o_irq
);
    // ========================================
    // comparator synchronisation
    logic [3:0] cmp_sync;
    lsmc_sync #(.WIDTH(4)) u_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_async ({i_above_rise_warn, i_below_fall_warn,
                   i_above_rise_rst, i_below_fall_rst}),
        .o_sync  (cmp_sync)
    );

    logic [3:0] cfg_reg;
    logic [3:0] cfg_next;
    logic [3:0] written_reg;
    logic [3:0] written_next;
    logic       flag_reg;
    logic       flag_next;
    logic       hold_reg;
    logic       hold_next;
    logic [2:0] ev_en_reg;
    logic [2:0] ev_en_next;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic [2:0] ev_stat;
    logic       below_fall;
    logic       above_rise;
    logic       active;
    logic       rst_en;
    logic       wr;
    logic       rd;

    // ========================================
    // monitor activity
    assign rst_en = !cfg_reg[LSMC_RSTDIS_BIT];
    always_comb
    begin
        // power disable off means monitoring; wait mode keeps it running
        active = !cfg_reg[LSMC_PWRDIS_BIT];
        if (i_stop_mode)
            active = active && cfg_reg[LSMC_STOPEN_BIT];
    end
    assign o_monitor_power = !cfg_reg[LSMC_PWRDIS_BIT];

    // trip level select picks comparator pair
    assign below_fall = cfg_reg[LSMC_TRIPSEL_BIT] ? cmp_sync[2] : cmp_sync[0];
    assign above_rise = cfg_reg[LSMC_TRIPSEL_BIT] ? cmp_sync[3] : cmp_sync[1];

    // ========================================
    // flag and reset hold
    always_comb
    begin
        flag_next = flag_reg;
        hold_next = hold_reg;
        if (active)
        begin
            if (below_fall)
                flag_next = 1'b1;
            else if (above_rise)
                flag_next = 1'b0;
            // below falling level, or not above rising level with flag set, of selected trip starts reset
            if (rst_en && (below_fall || (!above_rise && flag_next)))
                hold_next = 1'b1;
            else if (above_rise)
                hold_next = 1'b0;
        end
        else
        begin
            hold_next = 1'b0;
        end
        if (!rst_en)
            hold_next = 1'b0;
        // switching to warning while not above its rising level
        if (wr && i_paddr == LSMC_CONFIG_ADDR && active && !i_pwdata[LSMC_RSTDIS_BIT]
            && i_pwdata[LSMC_TRIPSEL_BIT] && !cfg_reg[LSMC_TRIPSEL_BIT] && !cmp_sync[3])
            hold_next = 1'b1;
    end
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            flag_reg <= 1'b0;
            hold_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            hold_reg <= hold_next;
        end
    end
    assign o_sys_reset = hold_reg;

    // ========================================
    // apb slave
    assign wr        = i_psel && i_penable && i_pwrite;
    assign rd        = i_psel && i_penable && !i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;

    always_comb
    begin
        cfg_next     = cfg_reg;
        written_next = written_reg;
        ev_en_next   = ev_en_reg;
        if (wr && i_paddr == LSMC_CONFIG_ADDR)
        begin
            // write-once bits lock; reset disable and trip select stay open
            for (int b = 0; b < 4; b++)
            begin
                if (!(LSMC_ONCE_MASK[b] && written_reg[b]))
                    cfg_next[b] = i_pwdata[b];
            end
            written_next = written_reg | LSMC_ONCE_MASK;
        end
        if (wr && i_paddr == LSMC_INT_EN)
            ev_en_next = i_pwdata[2:0];
    end
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cfg_reg     <= LSMC_CONFIG_RST;
            written_reg <= 4'h0;
            ev_en_reg   <= LSMC_EV_RST;
        end
        else
        begin
            cfg_reg     <= cfg_next;
            written_reg <= written_next;
            ev_en_reg   <= ev_en_next;
        end
    end

    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;
    // read word captured in the setup cycle so the data output leaves a flip-flop
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (i_psel && !i_penable && !i_pwrite)
        begin
            case (i_paddr)
                LSMC_STATUS_ADDR: rdata_next[LSMC_FLAG_BIT] = flag_reg;
                LSMC_CONFIG_ADDR: rdata_next[3:0] = cfg_reg;
                LSMC_INT_STAT:    rdata_next[2:0] = ev_stat;
                LSMC_INT_EN:      rdata_next[2:0] = ev_en_reg;
                default:          rdata_next = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= rdata_next;
    end
    // read data shown only in the access phase
    assign o_prdata = rd ? rdata_reg : 32'h0000_0000;

    // ========================================
    // status events for software; enabled events raise o_irq
    assign ev_set[LSMC_EV_FALL_BIT] = flag_next && !flag_reg;
    assign ev_set[LSMC_EV_RISE_BIT] = !flag_next && flag_reg;
    assign ev_set[LSMC_EV_RST_BIT]  = hold_next && !hold_reg;
    assign ev_clr = (wr && i_paddr == LSMC_INT_CLR) ? i_pwdata[2:0] : 3'h0;
    lsmc_events #(.N(3)) u_events (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_set  (ev_set),
        .i_clr  (ev_clr),
        .i_en   (ev_en_reg),
        .o_stat (ev_stat),
        .o_irq  (o_irq)
    );
endmodule : lsmc_ctrl

// ===== hw/lsmc_pkg.sv
// package of constants for the low supply monitor control block
// Notes on behaviour
// - monitor comes up enabled after reset
// - power disable set turns monitoring off
// - reset on falling threshold unless disabled
// - stop mode active needs power on, stop enable
// - trip select defaults reset level; 1 warning
// - switching to warning while low resets immediately
// - hold reset until rising threshold passed
// - flag set below falling, cleared above rising
// - i_nrst clears the flag; the monitor's own reset output leaves it set
// - flag follows comparator with resets disabled
// - monitor raises an interrupt request for enabled events
// - monitor keeps working in wait mode
// - reset disable and trip select rewritable
package lsmc_pkg;
    // ========================================
    // register map
    localparam logic [15:0] LSMC_STATUS_ADDR  = 16'hFE0C;
    localparam logic [15:0] LSMC_CONFIG_ADDR  = 16'hFE10;
    localparam logic [15:0] LSMC_INT_STAT     = 16'hFE14;
    localparam logic [15:0] LSMC_INT_CLR      = 16'hFE18;
    localparam logic [15:0] LSMC_INT_EN       = 16'hFE1C;
    // ========================================
    // field positions
    localparam int LSMC_FLAG_BIT    = 7;
    localparam int LSMC_STOPEN_BIT  = 0;
    localparam int LSMC_PWRDIS_BIT  = 1;
    localparam int LSMC_TRIPSEL_BIT = 2;
    localparam int LSMC_RSTDIS_BIT  = 3;
    localparam int LSMC_EV_FALL_BIT = 0;
    localparam int LSMC_EV_RISE_BIT = 1;
    localparam int LSMC_EV_RST_BIT  = 2;
    // ========================================
    // reset values and write-once mask
    localparam logic [7:0] LSMC_STATUS_RST = 8'h00;
    localparam logic [3:0] LSMC_CONFIG_RST = 4'h0;
    localparam logic [2:0] LSMC_EV_RST     = 3'h0;
    localparam logic [3:0] LSMC_ONCE_MASK  = 4'h3;
endpackage : lsmc_pkg

// ===== hw/lsmc_sync.sv
// two-flop synchroniser per bit
`timescale 1ns/1ps
module lsmc_sync
    import lsmc_pkg::*;
#(
    parameter int WIDTH = 2
)(
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    if (WIDTH < 1)
    begin : g_bad_width
        $error("width must be positive");
    end
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    // ========================================
    // two flip-flops per bit
    genvar g;
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
        always_ff @(posedge i_clk or negedge i_nrst)
        begin
            if (!i_nrst)
            begin
                meta_reg[g] <= 1'b0;
                sync_reg[g] <= 1'b0;
            end
            else
            begin
                meta_reg[g] <= i_async[g];
                sync_reg[g] <= meta_reg[g];
            end
        end
    end
    assign o_sync = sync_reg;
endmodule : lsmc_sync

// ===== hw/lsmc_events.sv
// sticky event bits with enable, clear and level output
`timescale 1ns/1ps
module lsmc_events
    import lsmc_pkg::*;
#(
    parameter int N = 3
)(
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic [N-1:0] i_set,
    input  wire logic [N-1:0] i_clr,
    input  wire logic [N-1:0] i_en,
    output logic      [N-1:0] o_stat,
    output logic              o_irq
);
    if (N < 1)
    begin : g_bad_count
        $error("need at least one event");
    end
    logic [N-1:0] stat_reg;
    logic [N-1:0] stat_next;
    // ========================================
    // set wins over clear
    always_comb
    begin
        stat_next = (stat_reg & ~i_clr) | i_set;
    end
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            stat_reg <= '0;
        else
            stat_reg <= stat_next;
    end
    assign o_stat = stat_reg;
    assign o_irq  = |(stat_reg & i_en);
endmodule : lsmc_events

// ===== verif/lsmc_supply_model.sv
// supply comparator model with hysteresis on both trip levels
`timescale 1ns/1ps
module lsmc_supply_model
#(
    parameter int RST_FALL  = 20,
    parameter int RST_RISE  = 30,
    parameter int WARN_FALL = 50,
    parameter int WARN_RISE = 60
)(
    input  wire logic [7:0] i_level,
    output logic            o_below_fall_rst,
    output logic            o_above_rise_rst,
    output logic            o_below_fall_warn,
    output logic            o_above_rise_warn
);
    // rising point sits above falling point, so mid levels assert neither
    assign o_below_fall_rst  = int'(i_level) < RST_FALL;
    assign o_above_rise_rst  = int'(i_level) > RST_RISE;
    assign o_below_fall_warn = int'(i_level) < WARN_FALL;
    assign o_above_rise_warn = int'(i_level) > WARN_RISE;
endmodule : lsmc_supply_model

// ===== verif/lsmc_properties.sv
// checker on the low supply monitor control ports
`timescale 1ns/1ps
module lsmc_properties
    import lsmc_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_below_fall_rst,
    input wire logic        i_above_rise_rst,
    input wire logic        i_above_rise_warn,
    input wire logic        i_stop_mode,
    input wire logic        o_monitor_power,
    input wire logic        o_sys_reset
);
    // ======
    // shadow of the rewritable config bits
    logic trip_reg;
    logic rdis_reg;
    logic on_w;
    logic act_w;
    assign on_w  = o_monitor_power && !rdis_reg && !i_stop_mode;
    assign act_w = on_w && !trip_reg;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            trip_reg <= 1'b0;
            rdis_reg <= 1'b0;
        end
        else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == LSMC_CONFIG_ADDR)
        begin
            trip_reg <= i_pwdata[LSMC_TRIPSEL_BIT];
            rdis_reg <= i_pwdata[LSMC_RSTDIS_BIT];
        end
    end
    // ======
    // properties
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    a_power_up: assert property (disable iff (1'b0) !i_nrst |-> o_monitor_power)
        else $error("monitor power low in reset");
    a_low_resets: assert property ((act_w && i_below_fall_rst)[*4] |-> o_sys_reset)
        else $error("no reset on low supply");
    a_reset_holds: assert property
        ((act_w && !i_above_rise_rst)[*3] ##0 o_sys_reset |=> o_sys_reset)
        else $error("reset dropped below rising point");
    a_reset_release: assert property ((act_w && i_above_rise_rst)[*4] |-> !o_sys_reset)
        else $error("reset held above rising point");
    a_rstdis_quiet: assert property (rdis_reg[*2] |-> !o_sys_reset)
        else $error("reset while resets disabled");
    a_power_quiet: assert property (!o_monitor_power[*2] |-> !o_sys_reset)
        else $error("reset while monitor off");
    a_warn_switch: assert property
        ((on_w && !i_above_rise_warn)[*3] ##0 $rose(trip_reg) |-> ##[0:3] o_sys_reset)
        else $error("no reset on warning switch");
    a_bus_answer: assert property (i_psel && i_penable |-> o_pready && !o_pslverr)
        else $error("bus access not accepted");
endmodule : lsmc_properties
bind lsmc_ctrl lsmc_properties u_props (.*);

// ===== verif/testbench.sv
// bench for the low supply monitor control
`timescale 1ns/1ps
module testbench
    import lsmc_pkg::*;
;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        stp = 1'b0, wt = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rd, prd;
    logic [7:0]  lvl = 8'h50;
    logic        rdy, bfr, arr, bfw, arw, mpw, srst, irq;
    int          err_total = 0, n_checks = 0, cyc = 0;
    lsmc_supply_model sup (.i_level(lvl), .o_below_fall_rst(bfr), .o_above_rise_rst(arr),
        .o_below_fall_warn(bfw), .o_above_rise_warn(arw));
    lsmc_ctrl dut (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(), .i_below_fall_rst(bfr), .i_above_rise_rst(arr),
        .i_below_fall_warn(bfw), .i_above_rise_warn(arw), .i_stop_mode(stp),
        .i_wait_mode(wt), .o_monitor_power(mpw), .o_sys_reset(srst), .o_irq(irq));
    always #4 clk = ~clk;
    // ======
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr  <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        rd = prd;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic go(input logic [7:0] v, input int n);
        lvl <= v;
        repeat (n) @(posedge clk);
    endtask : go
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            err_total++;
            stop_test();
        end
    end
    // ======
    // scenarios
    task automatic t_reset_flag();
        chk("power", 32'h1, mpw);
        apb(1'b0, LSMC_CONFIG_ADDR, 32'h0);
        chk("config", 32'h0, rd);
        wt <= 1'b1;
        go(8'h0A, 6);
        chk("reset low", 32'h1, srst);
        apb(1'b0, LSMC_STATUS_ADDR, 32'h0);
        chk("flag low", 32'h80, rd);
        go(8'h19, 6);
        chk("reset mid", 32'h1, srst);
        apb(1'b0, LSMC_STATUS_ADDR, 32'h0);
        chk("flag mid", 32'h80, rd);
        go(8'h50, 6);
        chk("reset high", 32'h0, srst);
        go(8'h0A, 6);
        lvl <= 8'h50;
        do_reset();
        apb(1'b0, LSMC_STATUS_ADDR, 32'h0);
        chk("flag reset", 32'h0, rd);
        $display("reset and flag test done");
    endtask : t_reset_flag
    task automatic t_power_stop();
        apb(1'b1, LSMC_CONFIG_ADDR, 32'h2);
        apb(1'b1, LSMC_CONFIG_ADDR, 32'h0);
        go(8'h0A, 6);
        chk("power off", 32'h0, mpw);
        chk("reset off", 32'h0, srst);
        lvl <= 8'h50;
        do_reset();
        apb(1'b1, LSMC_CONFIG_ADDR, 32'h1);
        stp <= 1'b1;
        go(8'h0A, 6);
        chk("reset stop", 32'h1, srst);
        go(8'h50, 6);
        stp <= 1'b0;
        $display("power and stop test done");
    endtask : t_power_stop
    task automatic t_polled();
        apb(1'b1, LSMC_CONFIG_ADDR, 32'h9);
        chk("irq idle", 32'h0, irq);
        apb(1'b1, LSMC_INT_EN, 32'h1);
        go(8'h0A, 6);
        chk("reset polled", 32'h0, srst);
        apb(1'b0, LSMC_STATUS_ADDR, 32'h0);
        chk("flag polled", 32'h80, rd);
        go(8'h50, 6);
        chk("irq set", 32'h1, irq);
        apb(1'b0, LSMC_INT_STAT, 32'h0);
        chk("events", 32'h7, rd);
        apb(1'b1, LSMC_INT_CLR, 32'h1);
        chk("irq clear", 32'h0, irq);
        apb(1'b0, LSMC_INT_STAT, 32'h0);
        chk("events left", 32'h6, rd);
        apb(1'b0, 16'hFE20, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("polled test done");
    endtask : t_polled
    task automatic t_warn();
        go(8'h28, 2);
        apb(1'b1, LSMC_CONFIG_ADDR, 32'h0);
        chk("reset armed", 32'h0, srst);
        apb(1'b1, LSMC_CONFIG_ADDR, 32'h4);
        go(8'h28, 4);
        chk("reset warn", 32'h1, srst);
        apb(1'b1, LSMC_CONFIG_ADDR, 32'h0);
        go(8'h28, 6);
        chk("reset dropped", 32'h0, srst);
        apb(1'b0, LSMC_CONFIG_ADDR, 32'h0);
        chk("config lock", 32'h1, rd);
        $display("warning level test done");
    endtask : t_warn
    // ======
    // main sequence
    initial
    begin
        do_reset();
        t_reset_flag();
        t_power_stop();
        t_polled();
        t_warn();
        stop_test();
    end
endmodule : testbench
